//--- rtcwd_pkg.sv
// constants shared by the slow-clock control and watchdog block
package rtcwd_pkg;
	// ---------------------------------------------
	// command opcodes
	// ---------------------------------------------
	localparam logic [7:0] OP_RTC_WRITE  = 8'h43;
	localparam logic [7:0] OP_RTC_READ   = 8'hC3;
	localparam logic [7:0] OP_INT_READ   = 8'hFE;
	localparam logic [7:0] OP_CAL_WRITE  = 8'h40;
	localparam logic [7:0] OP_CAL_READ   = 8'hC0;
	// ---------------------------------------------
	// control register fields and reset values
	// ---------------------------------------------
	localparam int         BIT_WDOG_ENABLE = 0;
	localparam int         BIT_WDOG_FLAG   = 1;
	localparam int         BIT_AM_LO       = 2;
	localparam int         BIT_AM_HI       = 3;
	localparam int         BIT_OSC_STOP_N  = 4;
	localparam int         BIT_OUT_EN      = 5;
	localparam int         BIT_BYPASS      = 6;
	localparam int         BIT_ALARM_FLAG  = 14;
	localparam logic [15:0] RTC_REG_RESET  = 16'h0000;
	localparam logic [3:0]  CAL_PERIOD_RESET = 4'h0;
	localparam logic [1:0] AM_NONE   = 2'h0;
	localparam logic [1:0] AM_MINUTE = 2'h1;
	localparam logic [1:0] AM_HOUR   = 2'h2;
	localparam logic [1:0] AM_BOTH   = 2'h3;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int         WDOG_TICKS_DEFAULT = 256;
	typedef enum logic [1:0] {CAL_IDLE, CAL_ALIGN, CAL_RUN} rtcwd_cal_type;
endpackage

//--- rtcwd_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module rtcwd_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

//--- rtcwd_ctrl.sv
// slow clock select, calibration window, alarm and watchdog control
// Behaviour
// - calibration window is one plus field
// - bypass bit selects external slow clock
// - output enable drives slow clock out
// - stop bit high halts the oscillator
// - alarm active when any mode bit set
// - mode selects minutes, hours or both
// - match on increment sets alarm flag
// - interrupt held until status read
// - counter at zero sets watchdog flag
// - flag cleared only by writing zero
// - clearing flag releases watchdog output
// - enable runs timer, disable releases output
`timescale 1ns/100ps
module rtcwd_ctrl
	import rtcwd_pkg::*;
#(
	parameter int WDOG_TICKS = rtcwd_pkg::WDOG_TICKS_DEFAULT,
	parameter int CAL_CNT_W  = 16
) (
	input  wire logic                 CLK_SYS_I,
	input  wire logic                 SYS_RST_I,
	input  wire logic                 CMD_VALID_I,
	input  wire logic [7:0]           CMD_OPCODE_I,
	input  wire logic [15:0]          CMD_WDATA_I,
	output logic      [15:0]          RDATA_O,
	output logic                      RDATA_VALID_O,
	input  wire logic                 SLOW_XTAL_I,
	input  wire logic                 SLOW_CLK_IN_PIN_I,
	input  wire logic                 FAST_OSC_I,
	output logic                      SLOW_CLK_OUT_PIN_O,
	input  wire logic                 CAL_START_I,
	output logic                      CAL_DONE_O,
	output logic      [CAL_CNT_W-1:0] CAL_COUNT_O,
	input  wire logic                 MINUTE_INC_I,
	input  wire logic                 HOUR_INC_I,
	input  wire logic [7:0]           MINUTES_I,
	input  wire logic [7:0]           HOURS_I,
	input  wire logic [7:0]           ALARM_MINUTES_I,
	input  wire logic [7:0]           ALARM_HOURS_I,
	input  wire logic                 INT_ENABLE_I,
	output logic                      INT_N_O,
	output logic                      WDOG_OUT_N_O,
	output logic                      WDOG_OUT_N_OE_O
);
	import rtcwd_pkg::*;

	// ---------------------------------------------
	// register state
	// ---------------------------------------------
	logic       wdog_enable;
	logic       wdog_flag;
	logic [1:0] alarm_mode;
	logic       osc_stop_n;
	logic       slow_clk_out_en;
	logic       slow_clk_bypass;
	logic [3:0] cal_period;
	logic       alarm_flag;
	logic [2:0] pins_sync;
	logic       slow_sel;
	logic       slow_prev;
	logic       fast_prev;
	logic       slow_tick;
	logic       fast_tick;
	logic       wr_rtc;
	logic       rd_int;
	logic       alarm_hit;
	logic       wdog_expire;

	function automatic logic is_cmd(input logic v, input logic [7:0] op, input logic [7:0] want);
		is_cmd = v && (op == want);
	endfunction

	rtcwd_sync #(.WIDTH(3)) u_sync (
		.clk_i (CLK_SYS_I),
		.rst_i (SYS_RST_I),
		.d_i   ({FAST_OSC_I, SLOW_CLK_IN_PIN_I, SLOW_XTAL_I}),
		.q_o   (pins_sync)
	);

	assign wr_rtc = is_cmd(CMD_VALID_I, CMD_OPCODE_I, OP_RTC_WRITE);
	assign rd_int = is_cmd(CMD_VALID_I, CMD_OPCODE_I, OP_INT_READ);

	// ---------------------------------------------
	// register writes
	// ---------------------------------------------
	// reserved ignored
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wdog_enable     <= RTC_REG_RESET[BIT_WDOG_ENABLE];
			alarm_mode      <= RTC_REG_RESET[BIT_AM_HI:BIT_AM_LO];
			osc_stop_n      <= RTC_REG_RESET[BIT_OSC_STOP_N];
			slow_clk_out_en <= RTC_REG_RESET[BIT_OUT_EN];
			slow_clk_bypass <= RTC_REG_RESET[BIT_BYPASS];
		end else if (wr_rtc) begin
			wdog_enable     <= CMD_WDATA_I[BIT_WDOG_ENABLE];
			alarm_mode      <= CMD_WDATA_I[BIT_AM_HI:BIT_AM_LO];
			osc_stop_n      <= CMD_WDATA_I[BIT_OSC_STOP_N];
			slow_clk_out_en <= CMD_WDATA_I[BIT_OUT_EN];
			slow_clk_bypass <= CMD_WDATA_I[BIT_BYPASS];
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cal_period <= CAL_PERIOD_RESET;
		end else if (is_cmd(CMD_VALID_I, CMD_OPCODE_I, OP_CAL_WRITE)) begin
			cal_period <= CMD_WDATA_I[3:0];
		end
	end

	// ---------------------------------------------
	// register reads
	// ---------------------------------------------
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RDATA_O       <= 16'h0000;
			RDATA_VALID_O <= 1'b0;
		end else begin
			RDATA_VALID_O <= 1'b0;
			RDATA_O       <= 16'h0000;
			if (is_cmd(CMD_VALID_I, CMD_OPCODE_I, OP_RTC_READ)) begin
				RDATA_VALID_O <= 1'b1;
				RDATA_O       <= {9'h000, slow_clk_bypass, slow_clk_out_en, osc_stop_n,
					alarm_mode, wdog_flag, wdog_enable};
			end else if (rd_int) begin
				RDATA_VALID_O                <= 1'b1;
				RDATA_O[BIT_ALARM_FLAG]      <= alarm_flag;
			end else if (is_cmd(CMD_VALID_I, CMD_OPCODE_I, OP_CAL_READ)) begin
				RDATA_VALID_O <= 1'b1;
				RDATA_O       <= {12'h000, cal_period};
			end
		end
	end

	// ---------------------------------------------
	// slow clock source and output
	// ---------------------------------------------
	// bypass select
	assign slow_sel = slow_clk_bypass ? pins_sync[1] : pins_sync[0];

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			slow_prev <= 1'b0;
			fast_prev <= 1'b0;
		end else begin
			slow_prev <= slow_sel;
			fast_prev <= pins_sync[2];
		end
	end

	assign slow_tick = slow_sel && !slow_prev && !osc_stop_n;
	assign fast_tick = pins_sync[2] && !fast_prev;

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			SLOW_CLK_OUT_PIN_O <= 1'b0;
		end else begin
			SLOW_CLK_OUT_PIN_O <= slow_clk_out_en && !osc_stop_n && slow_sel;
		end
	end

	// ---------------------------------------------
	// calibration window
	// ---------------------------------------------
	rtcwd_cal_type cal_state;
	logic [4:0]    cal_left;

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cal_state   <= CAL_IDLE;
			cal_left    <= 5'h00;
			CAL_COUNT_O <= '0;
			CAL_DONE_O  <= 1'b0;
		end else begin
			CAL_DONE_O <= 1'b0;
			case (cal_state)
				CAL_IDLE: begin
					if (CAL_START_I) begin
						cal_left  <= {1'b0, cal_period} + 5'h01;
						cal_state <= CAL_ALIGN;
					end
				end
				CAL_ALIGN: begin
					if (slow_tick) begin
						CAL_COUNT_O <= '0;
						cal_state   <= CAL_RUN;
					end
				end
				CAL_RUN: begin
					if (fast_tick) begin
						CAL_COUNT_O <= CAL_COUNT_O + 1'b1;
					end
					if (slow_tick) begin
						cal_left <= cal_left - 5'h01;
						if (cal_left == 5'h01) begin
							CAL_DONE_O <= 1'b1;
							cal_state  <= CAL_IDLE;
						end
					end
				end
				default: cal_state <= CAL_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// alarm
	// ---------------------------------------------
	// mode decode
	always_comb begin
		case (alarm_mode)
			AM_MINUTE: alarm_hit = MINUTE_INC_I && (MINUTES_I == ALARM_MINUTES_I);
			AM_HOUR:   alarm_hit = HOUR_INC_I && (HOURS_I == ALARM_HOURS_I);
			AM_BOTH:   alarm_hit = (MINUTE_INC_I || HOUR_INC_I)
				&& (MINUTES_I == ALARM_MINUTES_I) && (HOURS_I == ALARM_HOURS_I);
			default:   alarm_hit = 1'b0;
		endcase
	end

	// sticky flag, set beats read clear
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			alarm_flag <= 1'b0;
		end else if (alarm_hit) begin
			alarm_flag <= 1'b1;
		end else if (rd_int) begin
			alarm_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			INT_N_O <= 1'b1;
		end else begin
			INT_N_O <= !((alarm_hit || (alarm_flag && !rd_int)) && INT_ENABLE_I);
		end
	end

	// ---------------------------------------------
	// watchdog
	// ---------------------------------------------
	logic [$clog2(WDOG_TICKS+1)-1:0] wdog_cnt;
	localparam logic [$clog2(WDOG_TICKS+1)-1:0] WDOG_LOAD = WDOG_TICKS[$clog2(WDOG_TICKS+1)-1:0];

	// counts only when enabled; any control write reloads it
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wdog_cnt <= WDOG_LOAD;
		end else if (wr_rtc || !wdog_enable || wdog_expire) begin
			wdog_cnt <= WDOG_LOAD;
		end else if (slow_tick) begin
			wdog_cnt <= wdog_cnt - 1'b1;
		end
	end

	assign wdog_expire = wdog_enable && slow_tick && (wdog_cnt == 1);

	// flag set wins over write of zero
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wdog_flag <= RTC_REG_RESET[BIT_WDOG_FLAG];
		end else if (wdog_expire) begin
			wdog_flag <= 1'b1;
		end else if (wr_rtc && !CMD_WDATA_I[BIT_WDOG_FLAG]) begin
			wdog_flag <= 1'b0;
		end
	end

	// drive low until cleared or disabled
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			WDOG_OUT_N_OE_O <= 1'b0;
			WDOG_OUT_N_O    <= 1'b0;
		end else begin
			WDOG_OUT_N_O <= 1'b0;
			if (wdog_expire) begin
				WDOG_OUT_N_OE_O <= 1'b1;
			end else if ((wr_rtc && !CMD_WDATA_I[BIT_WDOG_FLAG]) || !wdog_enable) begin
				WDOG_OUT_N_OE_O <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);

	a_cal_window_len: assert property (
		(cal_state == CAL_IDLE && CAL_START_I) |=> (cal_left == $past(cal_period) + 5'h01))
		else $error("calibration window length wrong");
	a_bypass_source: assert property (
		slow_clk_bypass |-> (slow_sel == pins_sync[1]))
		else $error("bypass source not selected");
	a_out_enable_off: assert property (
		!slow_clk_out_en |=> !SLOW_CLK_OUT_PIN_O)
		else $error("slow clock out active while disabled");
	a_osc_stopped: assert property (
		osc_stop_n |-> !slow_tick)
		else $error("tick while oscillator stopped");
	a_no_alarm_mode: assert property (
		(alarm_mode == AM_NONE && !alarm_flag) |=> !alarm_flag)
		else $error("alarm set with no mode");
	a_minute_match: assert property (
		(alarm_mode == AM_MINUTE && MINUTE_INC_I && MINUTES_I == ALARM_MINUTES_I) |=> alarm_flag)
		else $error("minute alarm missed");
	a_alarm_pin: assert property (
		(alarm_hit && INT_ENABLE_I) |=> !INT_N_O)
		else $error("interrupt pin not asserted");
	a_alarm_held: assert property (
		(alarm_flag && !rd_int) |=> alarm_flag)
		else $error("alarm flag lost without read");
	a_wdog_flag_set: assert property (
		wdog_expire |=> wdog_flag && WDOG_OUT_N_OE_O)
		else $error("watchdog flag not set at zero");
	a_wdog_flag_hold: assert property (
		(wdog_flag && !wr_rtc) |=> wdog_flag)
		else $error("watchdog flag cleared without write");
	a_wdog_release: assert property (
		(wr_rtc && !CMD_WDATA_I[BIT_WDOG_FLAG] && !wdog_expire) |=> !WDOG_OUT_N_OE_O)
		else $error("watchdog output not released");
	a_wdog_disabled: assert property (
		(!wdog_enable && !wdog_expire) |=> !WDOG_OUT_N_OE_O)
		else $error("watchdog output driven while disabled");
	a_wdog_low_level: assert property (
		WDOG_OUT_N_OE_O |-> !WDOG_OUT_N_O)
		else $error("watchdog output not low");
	a_reserved_zero: assert property (
		$past(is_cmd(CMD_VALID_I, CMD_OPCODE_I, OP_RTC_READ)) |-> (RDATA_O[15:7] == 9'h000))
		else $error("reserved bits not zero");

	c_cal_done: cover property (CAL_DONE_O);
	c_alarm_int: cover property (!INT_N_O ##1 rd_int);
	c_wdog_fire: cover property (wdog_expire ##[1:20] (wr_rtc && !CMD_WDATA_I[BIT_WDOG_FLAG]));
endmodule

//--- rtcwd_host_model.sv
// host model issuing register commands to the control block
`timescale 1ns/100ps
module rtcwd_host_model (
	input  wire logic        clk_i,
	output logic             cmd_valid_o,
	output logic [7:0]       cmd_opcode_o,
	output logic [15:0]      cmd_wdata_o,
	input  wire logic [15:0] rdata_i,
	input  wire logic        rdata_valid_i
);
	initial begin
		cmd_valid_o  = 1'b0;
		cmd_opcode_o = 8'h00;
		cmd_wdata_o  = 16'h0000;
	end
	// ---------------------------------------------
	// command cycles
	// ---------------------------------------------
	task automatic issue(input logic [7:0] op, input logic [15:0] data);
		@(negedge clk_i);
		cmd_valid_o  = 1'b1;
		cmd_opcode_o = op;
		cmd_wdata_o  = data;
		@(negedge clk_i);
		cmd_valid_o  = 1'b0;
		// idle lines never repeat the last command, so a lax decode shows up
		cmd_opcode_o = ~op;
		cmd_wdata_o  = ~data;
	endtask
	// answer stands one cycle only, so it is taken right after the command
	task automatic read_reg(input logic [7:0] op, output logic [15:0] data, output logic vld);
		issue(op, 16'h0000);
		data = rdata_i;
		vld  = rdata_valid_i;
	endtask
endmodule

//--- test_rtcwd_ctrl.sv
// self-checking testbench of the slow-clock control and watchdog block
`timescale 1ns/100ps
module test_rtcwd_ctrl;
	import rtcwd_pkg::*;
	localparam int TICKS = 4;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cmd_valid;
	logic [7:0]  cmd_opcode;
	logic [15:0] cmd_wdata;
	logic [15:0] rdata;
	logic        rdata_valid;
	logic        slow_xtal = 1'b0;
	logic        slow_ext = 1'b0;
	logic        fast_osc = 1'b0;
	logic        slow_out;
	logic        cal_start = 1'b0;
	logic        cal_done;
	logic [15:0] cal_count;
	logic        min_inc = 1'b0;
	logic        hour_inc = 1'b0;
	logic [7:0]  minutes = 8'h00;
	logic [7:0]  hours = 8'h00;
	logic [7:0]  al_min = 8'h12;
	logic [7:0]  al_hour = 8'h05;
	logic        int_en = 1'b1;
	logic        int_n;
	logic        wdog_n;
	logic        wdog_oe;
	int          n_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          n;
	int          p;
	logic [7:0]  cm [3] = '{8'h12, 8'h33, 8'h12};
	logic [7:0]  ch [3] = '{8'h07, 8'h05, 8'h05};
	logic        ex;
	always #20 clk_sys = ~clk_sys;
	// ---------------------------------------------
	// pin clocks: slow 40 cycles, external 80, fast 8 offset by 4
	// ---------------------------------------------
	always @(negedge clk_sys) begin
		cyc       <= cyc + 1;
		slow_xtal <= (cyc % 40) < 20;
		slow_ext  <= (cyc % 80) < 40;
		fast_osc  <= ((cyc + 4) % 8) < 4;
	end
	rtcwd_host_model host (
		.clk_i         (clk_sys),
		.cmd_valid_o   (cmd_valid),
		.cmd_opcode_o  (cmd_opcode),
		.cmd_wdata_o   (cmd_wdata),
		.rdata_i       (rdata),
		.rdata_valid_i (rdata_valid)
	);
	rtcwd_ctrl #(.WDOG_TICKS(TICKS), .CAL_CNT_W(16)) DUT (
		.CLK_SYS_I          (clk_sys),
		.SYS_RST_I          (sys_rst),
		.CMD_VALID_I        (cmd_valid),
		.CMD_OPCODE_I       (cmd_opcode),
		.CMD_WDATA_I        (cmd_wdata),
		.RDATA_O            (rdata),
		.RDATA_VALID_O      (rdata_valid),
		.SLOW_XTAL_I        (slow_xtal),
		.SLOW_CLK_IN_PIN_I  (slow_ext),
		.FAST_OSC_I         (fast_osc),
		.SLOW_CLK_OUT_PIN_O (slow_out),
		.CAL_START_I        (cal_start),
		.CAL_DONE_O         (cal_done),
		.CAL_COUNT_O        (cal_count),
		.MINUTE_INC_I       (min_inc),
		.HOUR_INC_I         (hour_inc),
		.MINUTES_I          (minutes),
		.HOURS_I            (hours),
		.ALARM_MINUTES_I    (al_min),
		.ALARM_HOURS_I      (al_hour),
		.INT_ENABLE_I       (int_en),
		.INT_N_O            (int_n),
		.WDOG_OUT_N_O       (wdog_n),
		.WDOG_OUT_N_OE_O    (wdog_oe)
	);
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] op, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		host.read_reg(op, d, v);
		check({15'h0000, v}, 16'h0001, "read answer");
		check(d, exp, "read data");
	endtask
	task automatic wr(input logic [15:0] data);
		host.issue(OP_RTC_WRITE, data);
	endtask
	task automatic count_out(input int cycles, output int rises);
		logic prev;
		rises = 0;
		prev  = slow_out;
		repeat (cycles) begin
			@(negedge clk_sys);
			if (slow_out === 1'b1 && prev === 1'b0) begin
				rises++;
			end
			prev = slow_out;
		end
	endtask
	task automatic pulse_inc(input logic hr);
		@(negedge clk_sys);
		min_inc  = !hr;
		hour_inc = hr;
		@(negedge clk_sys);
		min_inc  = 1'b0;
		hour_inc = 1'b0;
	endtask
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard, 10000 cycles against the few thousand of the sequence
	initial begin
		#400000;
		n_errors++;
		test_done();
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (12) @(negedge clk_sys);
		sys_rst = 1'b0;
		check({14'h0000, int_n, wdog_oe}, 16'h0002, "reset outputs");
		rd(OP_RTC_READ, RTC_REG_RESET);
		rd(OP_CAL_READ, 16'h0000);
		wr(16'hFFFF);
		rd(OP_RTC_READ, 16'h007D);
		wr(16'h0000);
		host.issue(8'h55, 16'h0000);
		check({15'h0000, rdata_valid}, 16'h0000, "unknown opcode answered");
		wr(16'h0020);
		repeat (10) @(negedge clk_sys);
		count_out(160, n);
		check(16'(n), 16'h0004, "crystal on slow out");
		wr(16'h0060);
		repeat (10) @(negedge clk_sys);
		count_out(160, n);
		check(16'(n), 16'h0002, "bypass on slow out");
		wr(16'h0030);
		count_out(160, n);
		check({15'(n), slow_out}, 16'h0000, "stopped oscillator out");
		wr(16'h0011);
		repeat (400) @(negedge clk_sys);
		check({15'h0000, wdog_oe}, 16'h0000, "watchdog ran while stopped");
		wr(16'h0000);
		foreach (cm[i]) begin
			p = (i == 0) ? 0 : ((i == 1) ? 3 : 15);
			host.issue(OP_CAL_WRITE, 16'(p));
			rd(OP_CAL_READ, 16'(p));
			@(negedge clk_sys);
			cal_start = 1'b1;
			@(negedge clk_sys);
			cal_start = 1'b0;
			n = 0;
			while (cal_done !== 1'b1 && n < 1000) begin
				@(negedge clk_sys);
				n++;
			end
			check({15'h0000, n < 1000}, 16'h0001, "calibration timed out");
			check(cal_count, 16'(5 * (p + 1)), "calibration count");
		end
		wr(16'h0001);
		n = 0;
		while (wdog_oe !== 1'b1 && n < TICKS * 40 + 20) begin
			@(negedge clk_sys);
			n++;
		end
		check({14'h0000, wdog_oe, wdog_n}, 16'h0002, "watchdog expiry");
		check({15'h0000, n >= (TICKS - 1) * 40 - 2}, 16'h0001, "watchdog early");
		rd(OP_RTC_READ, 16'h0003);
		wr(16'h0003);
		repeat (3) @(negedge clk_sys);
		rd(OP_RTC_READ, 16'h0003);
		check({15'h0000, wdog_oe}, 16'h0001, "output held until clear");
		wr(16'h0001);
		check({15'h0000, wdog_oe}, 16'h0000, "output released");
		rd(OP_RTC_READ, 16'h0001);
		wr(16'h0000);
		repeat (400) @(negedge clk_sys);
		check({15'h0000, wdog_oe}, 16'h0000, "disabled watchdog");
		for (int m = 0; m < 4; m++) begin
			wr(16'(m << 2));
			foreach (cm[i]) begin
				ex = (i == 0) ? (m == 1) : ((i == 1) ? (m == 2) : (m >= 2));
				minutes = cm[i];
				hours   = ch[i];
				pulse_inc(i != 0);
				repeat (5) @(negedge clk_sys);
				check({15'h0000, int_n}, {15'h0000, !ex}, "alarm interrupt");
				rd(OP_INT_READ, ex ? 16'h4000 : 16'h0000);
				check({15'h0000, int_n}, 16'h0001, "interrupt after status read");
			end
		end
		int_en = 1'b0;
		wr(16'h0004);
		minutes = 8'h12;
		hours   = 8'h07;
		pulse_inc(1'b0);
		repeat (3) @(negedge clk_sys);
		check({15'h0000, int_n}, 16'h0001, "masked interrupt");
		rd(OP_INT_READ, 16'h4000);
		test_done();
	end
endmodule
